// *** rtl/fcs_map.svh ***
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
// APB register offsets of the controller
`define FCS_REG_CTRL    12'h000
`define FCS_REG_ADDR    12'h004
`define FCS_REG_DATA    12'h008
`define FCS_REG_STAT    12'h00C
`define FCS_REG_RDATA   12'h010
// Control field positions
`define FCS_CTRL_GO     0
`define FCS_CTRL_OP_LSB 4
// Status field positions
`define FCS_ST_BUSY     0
`define FCS_ST_DONE     1
`define FCS_ST_FAIL     2
// Flash command codes and unlock addresses
`define FCS_A_555       19'h00555
`define FCS_A_2AA       19'h002AA
`define FCS_D_AA        8'hAA
`define FCS_D_55        8'h55
`define FCS_D_RESET     8'hF0
`define FCS_D_IDENT     8'h90
`define FCS_D_PROG      8'hA0
`define FCS_D_ESETUP    8'h80
`define FCS_D_CHIP      8'h10
`define FCS_D_SECT      8'h30
`define FCS_D_SUSP      8'hB0
`define FCS_D_RESUME    8'h30
// Status bit positions on the flash data bus
`define FCS_POLL_BIT    7
`define FCS_TOGGLE_BIT  6
`define FCS_TMO_BIT     5
`define FCS_ETOG_BIT    2
// Strobe timing
`define FCS_STROBE_NS   40
`define FCS_CLK_NS      8
`define FCS_STROBE_CYC  ((`FCS_STROBE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
// Suspend wait, microseconds
`define FCS_SUSP_US     20
`define FCS_SUSP_CYC    ((`FCS_SUSP_US * 1000 + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`endif

// *** rtl/fcs_pkg.sv ***
package fcs_pkg;
  typedef enum logic [3:0] {
    FCS_OP_RESET, FCS_OP_IDENT, FCS_OP_PROG, FCS_OP_CHIP, FCS_OP_SECT,
    FCS_OP_SUSP, FCS_OP_RESUME, FCS_OP_READ
  } fcs_op_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0]  dout;
    logic        dq_oe_n;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
  } fcs_pins_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fcs_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } fcs_apb_rsp_t;
endpackage

// *** rtl/fcs_bus_cycle.sv ***
`timescale 1ns/1ps
`include "fcs_map.svh"
// One flash bus cycle: write or read, strobes held for a fixed time
module fcs_bus_cycle
  import fcs_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic              start_i,
  input  wire logic              write_i,
  input  wire logic [18:0]       addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic [7:0]        dq_i,
  output fcs_pkg::fcs_pins_t     pins_o,
  output logic                   done_o,
  output logic [7:0]             rdata_o
);
  import fcs_pkg::*;

  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} fcs_bc_t;
  typedef struct packed {
    fcs_bc_t     st;
    logic [3:0]  cnt;
    fcs_pins_t   pins;
    logic [7:0]  rdata;
    logic        done;
  } fcs_bc_state_t;

  fcs_bc_state_t s_r;
  fcs_bc_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      BC_IDLE: begin
        if (start_i) begin
          // Address settles before either strobe falls
          s_nxt.pins.addr    = addr_i;
          s_nxt.pins.dout    = wdata_i;
          s_nxt.pins.dq_oe_n = ~write_i;
          s_nxt.st           = BC_SETUP;
        end
      end
      BC_SETUP: begin
        // Chip enable and strobe fall together; address is latched there
        s_nxt.pins.ce_n = 1'b0;
        s_nxt.pins.we_n = ~s_r.pins.dq_oe_n ? 1'b0 : 1'b1;
        s_nxt.pins.oe_n = ~s_r.pins.dq_oe_n ? 1'b1 : 1'b0;
        s_nxt.cnt       = 4'(`FCS_STROBE_CYC);
        s_nxt.st        = BC_STROBE;
      end
      BC_STROBE: begin
        if (s_r.cnt > 4'h1) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else begin
          // Data stays valid across the rising edge of the strobes
          s_nxt.rdata     = dq_i;
          s_nxt.pins.ce_n = 1'b1;
          s_nxt.pins.we_n = 1'b1;
          s_nxt.pins.oe_n = 1'b1;
          s_nxt.st        = BC_HOLD;
        end
      end
      BC_HOLD: begin
        s_nxt.pins.dq_oe_n = 1'b1;
        s_nxt.done         = 1'b1;
        s_nxt.st           = BC_IDLE;
      end
    endcase
    if (!rstn_i) begin
      s_nxt = '0;
      s_nxt.pins.dq_oe_n = 1'b1;
      s_nxt.pins.ce_n    = 1'b1;
      s_nxt.pins.we_n    = 1'b1;
      s_nxt.pins.oe_n    = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    s_r <= s_nxt;
  end

  assign pins_o  = s_r.pins;
  assign done_o  = s_r.done;
  assign rdata_o = s_r.rdata;

  a_data_at_rise: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(s_r.pins.we_n) |-> !s_r.pins.dq_oe_n) else $error("write data released before strobe rise");
endmodule

// *** rtl/fcs_ctrl.sv ***
`timescale 1ns/1ps
`include "fcs_map.svh"
// How it works
// - Reset is one F0 write; sent to leave identification or after timeout
// - Every multi-cycle command opens with AA at 555 then 55 at 2AA
// - Identification: unlock pair then 90 at 555
// - Program: unlock pair, A0 at 555, data at target
// - Chip erase: unlock, 80 at 555, unlock, 10 at 555
// - Sector erase: five like chip erase, then 30 at sector address
module fcs_ctrl
  import fcs_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  fcs_pkg::fcs_apb_req_t  apb_i,
  output fcs_pkg::fcs_apb_rsp_t  apb_o,
  input  wire logic [7:0]        dq_i,
  output fcs_pkg::fcs_pins_t     pins_o
);
  import fcs_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [2:0] {ST_IDLE, ST_SEQ, ST_POLL, ST_WAIT, ST_DONE} fcs_st_t;
  typedef struct packed {
    fcs_st_t     st;
    fcs_op_t     op;
    logic [2:0]  step;
    logic [18:0] addr;
    logic [7:0]  data;
    logic [7:0]  rdata;
    logic        have_prev;
    logic [7:0]  prev;
    logic        busy;
    logic        done;
    logic        fail;
    logic        issue;
    logic        is_wr;
    logic [18:0] c_addr;
    logic [7:0]  c_data;
    logic [11:0] wcnt;
  } fcs_state_t;

  fcs_state_t s_r;
  fcs_state_t s_nxt;
  logic       cyc_done;
  logic [7:0] cyc_rdata;

  // ==========================================================
  // Sequence table: address and data of each write step
  function automatic logic [26:0] seq_word(input fcs_op_t op, input logic [2:0] step,
                                           input logic [18:0] a, input logic [7:0] d);
    logic [26:0] w;
    w = {`FCS_A_555, `FCS_D_RESET};
    unique case (step)
      3'd0: w = {`FCS_A_555, `FCS_D_AA};
      3'd1: w = {`FCS_A_2AA, `FCS_D_55};
      3'd2: w = {`FCS_A_555, (op == FCS_OP_IDENT) ? `FCS_D_IDENT :
                             (op == FCS_OP_PROG)  ? `FCS_D_PROG : `FCS_D_ESETUP};
      3'd3: w = (op == FCS_OP_PROG) ? {a, d} : {`FCS_A_555, `FCS_D_AA};
      3'd4: w = {`FCS_A_2AA, `FCS_D_55};
      default: w = (op == FCS_OP_CHIP) ? {`FCS_A_555, `FCS_D_CHIP}
                                       : {a[18:16], 16'h0000, `FCS_D_SECT};
    endcase
    return w;
  endfunction

  function automatic logic [2:0] seq_len(input fcs_op_t op);
    logic [2:0] n;
    n = 3'd1;
    unique case (op)
      FCS_OP_IDENT: n = 3'd3;
      FCS_OP_PROG:  n = 3'd4;
      FCS_OP_CHIP:  n = 3'd6;
      FCS_OP_SECT:  n = 3'd6;
      default:      n = 3'd1;
    endcase
    return n;
  endfunction

  // ==========================================================
  // Sequencer
  always_comb begin
    s_nxt       = s_r;
    s_nxt.issue = 1'b0;
    unique case (s_r.st)
      ST_IDLE: begin
        if (apb_i.psel && apb_i.penable && apb_i.pwrite && apb_i.paddr == `FCS_REG_CTRL
            && apb_i.pwdata[`FCS_CTRL_GO]) begin
          s_nxt.op        = fcs_op_t'(apb_i.pwdata[`FCS_CTRL_OP_LSB +: 4]);
          s_nxt.step      = 3'd0;
          s_nxt.busy      = 1'b1;
          s_nxt.done      = 1'b0;
          s_nxt.fail      = 1'b0;
          s_nxt.have_prev = 1'b0;
          s_nxt.st        = ST_SEQ;
        end
      end
      ST_SEQ: begin
        if (!s_r.issue && s_r.step == 3'd0 && !cyc_done) begin
          s_nxt.issue = 1'b1;
          s_nxt.is_wr = 1'b1;
          unique case (s_r.op)
            FCS_OP_RESET:  {s_nxt.c_addr, s_nxt.c_data} = {`FCS_A_555, `FCS_D_RESET};
            FCS_OP_SUSP:   {s_nxt.c_addr, s_nxt.c_data} = {`FCS_A_555, `FCS_D_SUSP};
            FCS_OP_RESUME: {s_nxt.c_addr, s_nxt.c_data} = {`FCS_A_555, `FCS_D_RESUME};
            FCS_OP_READ: begin
              s_nxt.is_wr  = 1'b0;
              s_nxt.c_addr = s_r.addr;
            end
            default:       {s_nxt.c_addr, s_nxt.c_data} = seq_word(s_r.op, 3'd0, s_r.addr, s_r.data);
          endcase
          s_nxt.step = 3'd1;
        end else if (cyc_done) begin
          if (s_r.step < seq_len(s_r.op)) begin
            // Next write of the unlock or command sequence
            s_nxt.issue = 1'b1;
            s_nxt.is_wr = 1'b1;
            {s_nxt.c_addr, s_nxt.c_data} = seq_word(s_r.op, s_r.step, s_r.addr, s_r.data);
            s_nxt.step  = s_r.step + 3'd1;
          end else if (s_r.op == FCS_OP_READ) begin
            s_nxt.rdata = cyc_rdata;
            s_nxt.st    = ST_DONE;
          end else if (s_r.op == FCS_OP_PROG || s_r.op == FCS_OP_CHIP || s_r.op == FCS_OP_SECT) begin
            // First status read; one read is outstanding at a time
            s_nxt.issue  = 1'b1;
            s_nxt.is_wr  = 1'b0;
            s_nxt.c_addr = s_r.addr;
            s_nxt.st     = ST_POLL;
          end else if (s_r.op == FCS_OP_SUSP) begin
            s_nxt.wcnt = 12'(`FCS_SUSP_CYC);
            s_nxt.st   = ST_WAIT;
          end else begin
            s_nxt.st = ST_DONE;
          end
        end
      end
      ST_POLL: begin
        // Read the status byte until the toggle bit stops inverting
        if (cyc_done) begin
          s_nxt.prev      = cyc_rdata;
          s_nxt.have_prev = 1'b1;
          s_nxt.rdata     = cyc_rdata;
          if (s_r.have_prev && cyc_rdata[`FCS_TOGGLE_BIT] == s_r.prev[`FCS_TOGGLE_BIT]) begin
            s_nxt.st = ST_DONE;
          end else if (s_r.have_prev && s_r.prev[`FCS_TMO_BIT] && cyc_rdata[`FCS_TMO_BIT]) begin
            s_nxt.fail = 1'b1;
            s_nxt.op   = FCS_OP_RESET;
            s_nxt.step = 3'd0;
            s_nxt.st   = ST_SEQ;
          end else begin
            // Next status read only once the previous one has finished
            s_nxt.issue  = 1'b1;
            s_nxt.is_wr  = 1'b0;
            s_nxt.c_addr = s_r.addr;
          end
        end
      end
      ST_WAIT: begin
        if (s_r.wcnt > 12'h001) begin
          s_nxt.wcnt = s_r.wcnt - 12'h001;
        end else begin
          s_nxt.st = ST_DONE;
        end
      end
      ST_DONE: begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.st   = ST_IDLE;
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // Register writes; ADDR and DATA only change while idle (writes while busy are ignored)
    if (apb_i.psel && apb_i.penable && apb_i.pwrite && s_r.st == ST_IDLE) begin
      if (apb_i.paddr == `FCS_REG_ADDR) s_nxt.addr = apb_i.pwdata[18:0];
      if (apb_i.paddr == `FCS_REG_DATA) s_nxt.data = apb_i.pwdata[7:0];
      if (apb_i.paddr == `FCS_REG_STAT && apb_i.pwdata[`FCS_ST_DONE]) s_nxt.done = 1'b0;
    end
    if (!rstn_i) begin
      s_nxt    = '0;
      s_nxt.st = ST_IDLE;
    end
  end

  always_ff @(posedge mclk_i) begin
    s_r <= s_nxt;
  end

  // ==========================================================
  // Flash bus cycle engine
  fcs_bus_cycle u_cycle (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .start_i (s_r.issue),
    .write_i (s_r.is_wr),
    .addr_i  (s_r.c_addr),
    .wdata_i (s_r.c_data),
    .dq_i    (dq_i),
    .pins_o  (pins_o),
    .done_o  (cyc_done),
    .rdata_o (cyc_rdata)
  );

  // ==========================================================
  // APB read side, zero wait states
  always_comb begin
    apb_o         = '0;
    apb_o.pready  = 1'b1;
    apb_o.pslverr = apb_i.psel && apb_i.paddr > `FCS_REG_RDATA;
    unique case (apb_i.paddr)
      `FCS_REG_CTRL:  apb_o.prdata = {28'h0000000, s_r.op};
      `FCS_REG_ADDR:  apb_o.prdata = {13'h0000, s_r.addr};
      `FCS_REG_DATA:  apb_o.prdata = {24'h000000, s_r.data};
      `FCS_REG_STAT:  apb_o.prdata = {29'h00000000, s_r.fail, s_r.done, s_r.busy};
      `FCS_REG_RDATA: apb_o.prdata = {24'h000000, s_r.rdata};
      default:        apb_o.prdata = 32'h00000000;
    endcase
  end

  a_unlock_first: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_r.issue && s_r.step == 3'd1 && s_r.op == FCS_OP_PROG |-> s_r.c_data == 8'hAA && s_r.c_addr == 19'h00555)
    else $error("program does not open with unlock");
  a_prog_cmd: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_r.issue && s_r.step == 3'd3 && s_r.op == FCS_OP_PROG |-> s_r.c_data == 8'hA0)
    else $error("program command byte wrong");
  a_susp_wait: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(s_r.st == ST_WAIT) |-> s_r.wcnt == 12'd2500) else $error("suspend wait wrong");
  a_chip_last: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_r.issue && s_r.step == 3'd6 && s_r.op == FCS_OP_CHIP |-> s_r.c_data == 8'h10)
    else $error("chip erase byte wrong");
  a_sect_last: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_r.issue && s_r.step == 3'd6 && s_r.op == FCS_OP_SECT |-> s_r.c_data == 8'h30 && s_r.c_addr[15:0] == 16'h0000)
    else $error("sector erase byte wrong");
  a_ident_cmd: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_r.issue && s_r.step == 3'd3 && s_r.op == FCS_OP_IDENT |-> s_r.c_data == 8'h90)
    else $error("identification byte wrong");
  a_fail_reset: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(s_r.fail) |-> s_r.op == FCS_OP_RESET ##[1:20] s_r.issue && s_r.c_data == 8'hF0)
    else $error("no reset after timeout");
  a_reset_byte: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_r.issue && s_r.op == FCS_OP_RESET |-> s_r.c_data == 8'hF0) else $error("reset byte wrong");
endmodule

// *** verif/fcs_flash_model.sv ***
`timescale 1ns/1ps
// ==========
// Behavioural flash device on the far side of the pins
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'hA5,  // Arbitrary
  parameter logic [7:0] DEV_ID = 8'h3C,  // Arbitrary
  parameter logic [7:0] PROT   = 8'h04,
  parameter int         PRG_NS = 2000,
  parameter int         ERS_NS = 20000
)(
  input  fcs_pkg::fcs_pins_t pins_i,
  input  wire logic [7:0]    dq_i,
  output logic [7:0]         dq_o
);
  logic [7:0]  mem [int];
  logic [7:0]  esel, pd;
  logic [18:0] wa;
  logic        ident, pact, eact, susp, sreq, chip, tmo, tog, etog;
  int          step;
  wire logic   wr = !pins_i.ce_n && !pins_i.we_n && pins_i.oe_n;
  wire logic   rd = !pins_i.ce_n && !pins_i.oe_n;

  initial begin
    {ident, pact, eact, susp, sreq, chip, tmo, tog, etog} = '0;
    {esel, pd, wa} = '0;
    step = 0;
    dq_o = 8'h00;
  end

  function automatic logic [7:0] arr(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  function automatic logic [7:0] rv(input logic [18:0] a);
    if (ident) return a[7:0] == 8'h00 ? MFR_ID : a[7:0] == 8'h01 ? DEV_ID : {7'h00, PROT[a[18:16]]};
    if (pact || tmo) return {~pd[7], tog, tmo, 5'h00};
    if (eact && (!susp || esel[a[18:16]])) return {susp, tog, 3'h0, etog, 2'h0};
    return arr(a);
  endfunction

  // ==========
  // Read cycles
  always @(posedge rd) dq_o = rv(pins_i.addr);
  always @(negedge rd) begin
    if (pact || tmo || (eact && !susp)) tog = !tog;
    if (eact && esel[pins_i.addr[18:16]]) etog = !etog;
    dq_o = ~dq_o;  // Released bus shows no stale value
  end

  // ==========
  // Write cycles and command decode
  always @(posedge wr) wa = pins_i.addr;
  always @(negedge wr) cmd(wa, dq_i);

  task automatic cmd(input logic [18:0] a, input logic [7:0] d);
    if ($isunknown({a, d}) || pact) return;
    if (eact && !susp) begin
      if (!chip && d == 8'hB0) sreq = 1'b1;
      return;
    end
    if (step == 0 && d == 8'hF0) begin ident = 1'b0; tmo = 1'b0; end
    else if (step == 0 && susp && d == 8'h30) susp = 1'b0;
    else if (step == 0 && a == 19'h00555 && d == 8'hAA) step = 1;
    else if (step == 1 && a == 19'h002AA && d == 8'h55) step = 2;
    else if (step == 2 && a == 19'h00555 && d == 8'h90 && !susp) begin ident = 1'b1; step = 0; end
    else if (step == 2 && a == 19'h00555 && d == 8'hA0) step = 3;
    else if (step == 2 && a == 19'h00555 && d == 8'h80 && !susp) step = 4;
    else if (step == 4 && a == 19'h00555 && d == 8'hAA) step = 5;
    else if (step == 5 && a == 19'h002AA && d == 8'h55) step = 6;
    else if (step == 3) begin step = 0; fork prog(a, d); join_none end
    else if (step == 6 && a == 19'h00555 && d == 8'h10) begin step = 0; chip = 1'b1; fork erase(8'hFF); join_none end
    else if (step == 6 && d == 8'h30) begin step = 0; chip = 1'b0; fork erase(8'h01 << a[18:16]); join_none end
    else begin step = 0; ident = 1'b0; end
  endtask

  task automatic prog(input logic [18:0] a, input logic [7:0] d);
    pact = 1'b1;
    pd = d;
    #(PRG_NS);
    if (!PROT[a[18:16]]) begin
      if ((d & ~arr(a)) != 8'h00) tmo = 1'b1;
      else mem[a] = arr(a) & d;
    end
    pact = 1'b0;
  endtask

  task automatic erase(input logic [7:0] sel);
    int q[$];
    eact = 1'b1;
    esel = sel;
    foreach (mem[k]) if (sel[k[18:16]] && !PROT[k[18:16]]) q.push_back(k);
    foreach (q[i]) mem[q[i]] = 8'h00;
    for (int i = 0; i < 100; i++) begin
      #(ERS_NS / 100);
      if (sreq) begin susp = 1'b1; sreq = 1'b0; end
      wait (!susp);
    end
    foreach (q[i]) mem.delete(q[i]);
    {eact, esel} = '0;
  endtask
endmodule

// *** verif/fcs_ctrl_test.sv ***
`timescale 1ns/1ps
`include "fcs_map.svh"
// ==========
// Controller driven over APB against the flash model
module fcs_ctrl_test;
  import fcs_pkg::*;
  localparam logic [7:0] MFR_ID = 8'hA5;  // Arbitrary
  localparam logic [7:0] DEV_ID = 8'h3C;  // Arbitrary
  logic             mclk_i;
  logic             rstn_i;
  fcs_apb_req_t     req;
  fcs_apb_rsp_t     rsp;
  fcs_pins_t        pins;
  logic [7:0]       fl_q;
  wire logic [7:0]  dq = pins.dq_oe_n ? fl_q : pins.dout;
  logic [31:0]      rd;
  logic [31:0]      st;
  logic             slverr;
  int               err_total;
  int               samples_checked;

  fcs_ctrl i_fcs_ctrl (.mclk_i(mclk_i), .rstn_i(rstn_i), .apb_i(req), .apb_o(rsp), .dq_i(dq), .pins_o(pins));
  fcs_flash_model #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID)) i_fcs_flash_model (.pins_i(pins), .dq_i(dq), .dq_o(fl_q));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // ==========
  // Tasks
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge mclk_i);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      err_total++;
      conclude();
    end
    rd = rsp.prdata;
    slverr = rsp.pslverr;
    req <= '0;
    @(posedge mclk_i);
  endtask

  task automatic run(input fcs_op_t op, input logic [18:0] a, input logic [7:0] d);
    int n;
    apb(1'b1, `FCS_REG_ADDR, {13'h0000, a});
    apb(1'b1, `FCS_REG_DATA, {24'h000000, d});
    apb(1'b1, `FCS_REG_CTRL, {24'h000000, op, 4'h1});
    n = 0;
    do begin
      apb(1'b0, `FCS_REG_STAT, '0);
      n++;
    end while (rd[`FCS_ST_DONE] !== 1'b1 && n < 20000);
    if (rd[`FCS_ST_DONE] !== 1'b1) begin
      err_total++;
      conclude();
    end
    st = rd;
    apb(1'b1, `FCS_REG_STAT, 32'h0000_0002);
  endtask

  task automatic rdchk(input logic [18:0] a, input logic [7:0] exp);
    run(FCS_OP_READ, a, 8'h00);
    apb(1'b0, `FCS_REG_RDATA, '0);
    chk(rd, {24'h000000, exp});
  endtask

  // ==========
  // Sequence
  initial begin
    req = '0;
    rstn_i = 1'b0;
    err_total = 0;
    samples_checked = 0;
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    apb(1'b0, `FCS_REG_STAT, '0);
    chk(rd, '0);
    apb(1'b0, 12'h020, '0);
    chk(slverr, 1'b1);
    run(FCS_OP_PROG, 19'h10010, 8'h5A);
    apb(1'b0, `FCS_REG_ADDR, '0);
    chk(rd, 32'h00010010);
    apb(1'b0, `FCS_REG_DATA, '0);
    chk(rd, 32'h0000005A);
    apb(1'b0, `FCS_REG_CTRL, '0);
    chk(rd, 32'h00000002);
    rdchk(19'h10010, 8'h5A);
    run(FCS_OP_PROG, 19'h10010, 8'h0A);
    chk(st[`FCS_ST_FAIL], 1'b0);
    rdchk(19'h10010, 8'h0A);
    run(FCS_OP_PROG, 19'h10010, 8'hF0);
    chk(st[`FCS_ST_FAIL], 1'b1);
    rdchk(19'h10010, 8'h0A);
    run(FCS_OP_PROG, 19'h20000, 8'h00);
    chk(st[`FCS_ST_FAIL], 1'b0);
    rdchk(19'h20000, 8'hFF);
    run(FCS_OP_IDENT, 19'h00000, 8'h00);
    rdchk(19'h00000, MFR_ID);
    rdchk(19'h30001, DEV_ID);
    rdchk(19'h00000, MFR_ID);
    rdchk(19'h20002, 8'h01);
    rdchk(19'h10002, 8'h00);
    run(FCS_OP_RESET, 19'h00000, 8'h00);
    rdchk(19'h10010, 8'h0A);
    run(FCS_OP_PROG, 19'h00020, 8'h33);
    run(FCS_OP_SUSP, 19'h00000, 8'h00);
    run(FCS_OP_RESUME, 19'h00000, 8'h00);
    rdchk(19'h00020, 8'h33);
    run(FCS_OP_SECT, 19'h10000, 8'h00);
    rdchk(19'h10010, 8'hFF);
    rdchk(19'h00020, 8'h33);
    run(FCS_OP_CHIP, 19'h00000, 8'h00);
    rdchk(19'h00020, 8'hFF);
    conclude();
  end
endmodule
